// *** hw/icap_pkg.sv ***
// Purpose: shared constants and types for the capture block
// Assumes: 16-bit registers, plain strobe register port
// Notes:   offsets are word indices on the register port
package icap_pkg;
	localparam int          NUM_CH       = 8;
	localparam int          FIFO_DEPTH   = 4;
	localparam int          CNT_W        = 16;
	localparam logic [7:0]  ADDR_T2_CTRL = 8'h00;
	localparam logic [7:0]  ADDR_T3_CTRL = 8'h01;
	localparam logic [7:0]  ADDR_T2_CNT  = 8'h02;
	localparam logic [7:0]  ADDR_T3_CNT  = 8'h03;
	localparam logic [7:0]  ADDR_CH_BASE = 8'h10;
	localparam logic [7:0]  ADDR_BUF_BASE = 8'h20;
	localparam int          BIT_RUN      = 15;
	localparam int          BIT_IDLE     = 13;
	localparam int          BIT_GATE     = 6;
	localparam int          BIT_PS_HI    = 5;
	localparam int          BIT_PS_LO    = 4;
	localparam int          BIT_PAIR     = 3;
	localparam int          BIT_CS       = 1;
	localparam logic [15:0] T3_MASK      = 16'hA072;
	localparam logic [15:0] T2_MASK      = 16'hA07A;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [7:0]  PS_DIV1      = 8'h00;
	localparam logic [7:0]  PS_DIV8      = 8'h07;
	localparam logic [7:0]  PS_DIV64     = 8'h3F;
	localparam logic [7:0]  PS_DIV256    = 8'hFF;
	localparam logic [3:0]  EDGE_DIV4    = 4'h3;
	localparam logic [3:0]  EDGE_DIV16   = 4'hF;

	typedef enum logic [2:0] {
		ICAP_OFF   = 3'b000,
		ICAP_EVERY = 3'b001,
		ICAP_FALL  = 3'b010,
		ICAP_RISE  = 3'b011,
		ICAP_DIV4  = 3'b100,
		ICAP_DIV16 = 3'b101,
		ICAP_INTR  = 3'b111
	} icap_mode_t;

	// per-channel control: [7] timer sel, [6:5] threshold-1, [2:0] mode
	typedef struct packed {
		logic       tmr_sel;
		logic [1:0] thresh;
		icap_mode_t mode;
	} icap_chctl_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} icap_bus_t;
endpackage : icap_pkg

// *** hw/icap_top.sv ***
// Purpose: input capture channels with two 16-bit time-base timers
// Assumes: pins and external clocks asynchronous to sys_clk
// Notes:   external clock counts on synchronised rising edges
`timescale 1ns/10ps
module icap_top (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// register port
	input  wire icap_pkg::icap_bus_t       bus,
	output logic [15:0]                    rdata,
	// device state
	input  wire logic                      cpu_idle,
	input  wire logic                      cpu_sleep,
	// pins
	input  wire logic [7:0]                capture_input_pin,
	input  wire logic                      timer2_external_clock_pin,
	input  wire logic                      timer3_external_clock_pin,
	input  wire logic                      timer2_gate_pin,
	input  wire logic                      timer3_gate_pin,
	// events
	output logic [7:0]                     capture_irq,
	output logic                           wake_req
);
	localparam int N = icap_pkg::NUM_CH;
	localparam int D = icap_pkg::FIFO_DEPTH;

	function automatic logic [7:0] ps_limit(input logic [1:0] code);
		unique case (code)
			2'b00: ps_limit = icap_pkg::PS_DIV1;
			2'b01: ps_limit = icap_pkg::PS_DIV8;
			2'b10: ps_limit = icap_pkg::PS_DIV64;
			2'b11: ps_limit = icap_pkg::PS_DIV256;
		endcase
	endfunction : ps_limit

	// synchronisers: pins and external clocks
	logic [N+3:0] sync1;
	logic [N+3:0] sync2;
	logic [N+3:0] sync3;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= {timer3_gate_pin, timer2_gate_pin,
				timer3_external_clock_pin, timer2_external_clock_pin,
				capture_input_pin};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	logic [N-1:0] pin_s;
	logic [N-1:0] pin_rise;
	logic [N-1:0] pin_fall;
	logic         t2_xedge;
	logic         t3_xedge;
	logic         t2_gate;
	logic         t3_gate;
	assign pin_s    = sync2[N-1:0];
	assign pin_rise = sync2[N-1:0] & ~sync3[N-1:0];
	assign pin_fall = ~sync2[N-1:0] & sync3[N-1:0];
	assign t2_xedge = sync2[N] & ~sync3[N];
	assign t3_xedge = sync2[N+1] & ~sync3[N+1];
	assign t2_gate  = sync2[N+2];
	assign t3_gate  = sync2[N+3];

	// timer state
	logic [15:0] t2_ctl;
	logic [15:0] t3_ctl;
	logic [15:0] t2_cnt;
	logic [15:0] t3_cnt;
	logic [7:0]  t2_ps;
	logic [7:0]  t3_ps;
	logic [15:0] next_t2_ctl;
	logic [15:0] next_t3_ctl;
	logic [15:0] next_t2_cnt;
	logic [15:0] next_t3_cnt;
	logic [7:0]  next_t2_ps;
	logic [7:0]  next_t3_ps;
	logic        pair;
	logic        t2_tick;
	logic        t3_tick;
	logic        t2_on;
	logic        t3_on;
	logic        t2_carry;

	assign pair = t2_ctl[icap_pkg::BIT_PAIR];

	always_comb begin
		next_t2_ctl = t2_ctl;
		next_t3_ctl = t3_ctl;
		next_t2_cnt = t2_cnt;
		next_t3_cnt = t3_cnt;
		next_t2_ps  = t2_ps;
		next_t3_ps  = t3_ps;
		t2_tick = t2_ctl[icap_pkg::BIT_CS] ? t2_xedge :
			(!t2_ctl[icap_pkg::BIT_GATE] || t2_gate);
		t3_tick = t3_ctl[icap_pkg::BIT_CS] ? t3_xedge :
			(!t3_ctl[icap_pkg::BIT_GATE] || t3_gate);
		t2_on = t2_ctl[icap_pkg::BIT_RUN] &&
			!(cpu_idle && (pair ? t3_ctl[icap_pkg::BIT_IDLE] :
			t2_ctl[icap_pkg::BIT_IDLE]));
		t3_on = t3_ctl[icap_pkg::BIT_RUN] &&
			!(cpu_idle && t3_ctl[icap_pkg::BIT_IDLE]);
		t2_carry = 1'b0;
		if (t2_on && t2_tick) begin
			if (t2_ps >= ps_limit(t2_ctl[icap_pkg::BIT_PS_HI:
				icap_pkg::BIT_PS_LO])) begin
				next_t2_ps  = '0;
				next_t2_cnt = t2_cnt + 16'h0001;
				t2_carry    = (t2_cnt == 16'hFFFF);
			end else begin
				next_t2_ps = t2_ps + 8'h01;
			end
		end
		if (pair) begin
			if (t2_carry) begin
				next_t3_cnt = t3_cnt + 16'h0001;
			end
		end else if (t3_on && t3_tick) begin
			if (t3_ps >= ps_limit(t3_ctl[icap_pkg::BIT_PS_HI:
				icap_pkg::BIT_PS_LO])) begin
				next_t3_ps  = '0;
				next_t3_cnt = t3_cnt + 16'h0001;
			end else begin
				next_t3_ps = t3_ps + 8'h01;
			end
		end
		if (bus.wr) begin
			unique case (bus.addr)
				icap_pkg::ADDR_T2_CTRL: begin
					next_t2_ctl = bus.wdata & icap_pkg::T2_MASK;
				end
				icap_pkg::ADDR_T3_CTRL: begin
					next_t3_ctl = bus.wdata & icap_pkg::T3_MASK;
				end
				icap_pkg::ADDR_T2_CNT: begin
					next_t2_cnt = bus.wdata;
				end
				icap_pkg::ADDR_T3_CNT: begin
					next_t3_cnt = bus.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			t2_ctl <= icap_pkg::CTRL_RESET;
			t3_ctl <= icap_pkg::CTRL_RESET;
			t2_cnt <= '0;
			t3_cnt <= '0;
			t2_ps  <= '0;
			t3_ps  <= '0;
		end else begin
			t2_ctl <= next_t2_ctl;
			t3_ctl <= next_t3_ctl;
			t2_cnt <= next_t2_cnt;
			t3_cnt <= next_t3_cnt;
			t2_ps  <= next_t2_ps;
			t3_ps  <= next_t3_ps;
		end
	end

	// capture channels
	icap_pkg::icap_chctl_t chctl      [N];
	icap_pkg::icap_chctl_t next_chctl [N];
	logic [15:0]           fifo       [N][D];
	logic [15:0]           next_fifo  [N][D];
	logic [2:0]            fill       [N];
	logic [2:0]            next_fill  [N];
	logic [3:0]            ecnt       [N];
	logic [3:0]            next_ecnt  [N];
	logic [N-1:0]          ovf;
	logic [N-1:0]          next_ovf;
	logic [N-1:0]          irq;
	logic [N-1:0]          next_irq;
	logic [N-1:0]          hit;

	always_comb begin
		for (int c = 0; c < N; c++) begin
			logic       pop;
			logic       set_ev;
			logic [2:0] f;
			pop = 1'b0;
			set_ev = 1'b0;
			f   = fill[c];
			next_chctl[c] = chctl[c];
			next_ecnt[c]  = ecnt[c];
			next_fifo[c]  = fifo[c];
			next_ovf[c]   = ovf[c];
			next_irq[c]   = irq[c];
			hit[c]        = 1'b0;
			unique case (chctl[c].mode)
				icap_pkg::ICAP_EVERY: hit[c] = pin_rise[c] | pin_fall[c];
				icap_pkg::ICAP_FALL:  hit[c] = pin_fall[c];
				icap_pkg::ICAP_RISE:  hit[c] = pin_rise[c];
				icap_pkg::ICAP_DIV4: begin
					if (pin_rise[c]) begin
						hit[c] = (ecnt[c][1:0] == icap_pkg::EDGE_DIV4[1:0]);
						next_ecnt[c] = hit[c] ? 4'h0 : ecnt[c] + 4'h1;
					end
				end
				icap_pkg::ICAP_DIV16: begin
					if (pin_rise[c]) begin
						hit[c] = (ecnt[c] == icap_pkg::EDGE_DIV16);
						next_ecnt[c] = ecnt[c] + 4'h1;
					end
				end
				icap_pkg::ICAP_INTR: begin
					if (pin_rise[c]) begin
						next_irq[c] = 1'b1;
						set_ev      = 1'b1;
					end
				end
				default: hit[c] = 1'b0;
			endcase
			if (bus.rd && bus.addr == icap_pkg::ADDR_BUF_BASE + 8'(c)
				&& f != 3'h0) begin
				pop = 1'b1;
				for (int k = 0; k < D - 1; k++) begin
					next_fifo[c][k] = fifo[c][k+1];
				end
				f = f - 3'h1;
			end
			if (hit[c]) begin
				if (f == 3'(D)) begin
					next_ovf[c] = 1'b1;
				end else begin
					next_fifo[c][f[1:0]] = chctl[c].tmr_sel ? t2_cnt : t3_cnt;
					f = f + 3'h1;
					if (f == {1'b0, chctl[c].thresh} + 3'h1) begin
						next_irq[c] = 1'b1;
						set_ev      = 1'b1;
					end
				end
			end
			next_fill[c] = f;
			if (bus.wr && bus.addr == icap_pkg::ADDR_CH_BASE + 8'(c)) begin
				next_chctl[c] = icap_pkg::icap_chctl_t'({bus.wdata[7:5],
					bus.wdata[2:0]});
				next_ecnt[c]  = '0;
				if (bus.wdata[2:0] == icap_pkg::ICAP_OFF) begin
					next_fill[c] = '0;
					next_ovf[c]  = 1'b0;
				end
				// set wins over a clear in the same cycle
				if (bus.wdata[8]) begin
					next_irq[c] = set_ev;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int c = 0; c < N; c++) begin
				chctl[c] <= '0;
				fill[c]  <= '0;
				ecnt[c]  <= '0;
				for (int k = 0; k < D; k++) begin
					fifo[c][k] <= '0;
				end
			end
			ovf <= '0;
			irq <= '0;
		end else begin
			chctl <= next_chctl;
			fill  <= next_fill;
			ecnt  <= next_ecnt;
			fifo  <= next_fifo;
			ovf   <= next_ovf;
			irq   <= next_irq;
		end
	end

	// read data and outputs
	logic [15:0] next_rdata;
	logic        next_wake;
	always_comb begin
		next_rdata = '0;
		if (bus.rd) begin
			if (bus.addr == icap_pkg::ADDR_T2_CTRL) begin
				next_rdata = t2_ctl;
			end else if (bus.addr == icap_pkg::ADDR_T3_CTRL) begin
				next_rdata = t3_ctl;
			end else if (bus.addr == icap_pkg::ADDR_T2_CNT) begin
				next_rdata = t2_cnt;
			end else if (bus.addr == icap_pkg::ADDR_T3_CNT) begin
				next_rdata = t3_cnt;
			end
			for (int c = 0; c < N; c++) begin
				if (bus.addr == icap_pkg::ADDR_CH_BASE + 8'(c)) begin
					next_rdata = {7'h00, irq[c], chctl[c].tmr_sel,
						chctl[c].thresh, ovf[c], fill[c] != 3'h0,
						chctl[c].mode};
				end
				if (bus.addr == icap_pkg::ADDR_BUF_BASE + 8'(c)) begin
					next_rdata = fifo[c][0];
				end
			end
		end
		// wake on capture in sleep or idle
		next_wake = (cpu_sleep || cpu_idle) && ((|hit) ||
			(|(next_irq & ~irq)));
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdata    <= '0;
			wake_req <= 1'b0;
		end else begin
			rdata    <= next_rdata;
			wake_req <= next_wake;
		end
	end
	assign capture_irq = irq;
	logic unused_pin;
	assign unused_pin = ^pin_s;
endmodule : icap_top

// *** tb/icap_props.sv ***
// Purpose: port checks for the capture block
// Assumes: master keeps to the strobe protocol
// Notes:   helpers mirror control writes
`timescale 1ns/10ps
module icap_props (
	// clock and reset
	input wire logic                sys_clk,
	input wire logic                reset,
	// watched ports
	input wire icap_pkg::icap_bus_t bus,
	input wire logic [15:0]         rdata,
	input wire logic                cpu_idle,
	input wire logic                cpu_sleep,
	input wire logic [7:0]          capture_irq,
	input wire logic                wake_req
);
	logic [15:0] t2w;
	logic [15:0] t3w;
	logic [7:0]  c0w;
	logic        ran2;
	logic        ran3;
	wire         clr = bus.wr & bus.wdata[8];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			t2w  <= 16'h0000;
			t3w  <= 16'h0000;
			c0w  <= 8'h00;
			ran2 <= 1'b0;
			ran3 <= 1'b0;
		end else begin
			ran2 <= ran2 | t2w[15];
			ran3 <= ran3 | t3w[15] | t2w[3];
			if (bus.wr && bus.addr == icap_pkg::ADDR_T2_CTRL)
				t2w <= bus.wdata & icap_pkg::T2_MASK;
			if (bus.wr && bus.addr == icap_pkg::ADDR_T3_CTRL)
				t3w <= bus.wdata & icap_pkg::T3_MASK;
			if (bus.wr && bus.addr == icap_pkg::ADDR_CH_BASE)
				c0w <= bus.wdata[7:0];
		end
	end
	t3_ctrl_read_a: assert property (
		$past(bus.rd) && $past(bus.addr) == icap_pkg::ADDR_T3_CTRL
		|-> rdata == $past(t3w)) else $error("t3 control readback wrong");
	t2_ctrl_read_a: assert property (
		$past(bus.rd) && $past(bus.addr) == icap_pkg::ADDR_T2_CTRL
		|-> rdata == $past(t2w)) else $error("t2 control readback wrong");
	ch_ctl_read_a: assert property (
		$past(bus.rd) && $past(bus.addr) == icap_pkg::ADDR_CH_BASE
		|-> rdata[7:5] == $past(c0w[7:5]) && rdata[2:0] == $past(c0w[2:0]))
		else $error("channel control readback wrong");
	no_chan_read_a: assert property (
		$past(bus.rd) && $past(bus.addr) inside {8'h18, 8'h28}
		|-> rdata == 16'h0000) else $error("unmapped read not zero");
	t2_idle_cnt_a: assert property (
		$past(bus.rd) && $past(bus.addr) == icap_pkg::ADDR_T2_CNT
		&& !$past(ran2) |-> rdata == 16'h0000) else $error("t2 moved unrun");
	t3_idle_cnt_a: assert property (
		$past(bus.rd) && $past(bus.addr) == icap_pkg::ADDR_T3_CNT
		&& !$past(ran3) |-> rdata == 16'h0000) else $error("t3 moved unrun");
	wake_state_a: assert property (
		wake_req |-> $past(cpu_idle) || $past(cpu_sleep))
		else $error("wake outside sleep or idle");
	irq_sticky_a: assert property (
		|($past(capture_irq) & ~capture_irq) |-> $past(clr))
		else $error("irq dropped without clear");
endmodule : icap_props

// *** tb/icap_pulse_src.sv ***
// Purpose: pulse source on one capture pin
// Assumes: start is a one-cycle request
// Notes:   pin rests low between bursts
`timescale 1ns/10ps
module icap_pulse_src (
	// clock and request
	input  wire logic       sys_clk,
	input  wire logic       start,
	input  wire logic [7:0] n_pulses,
	input  wire logic [7:0] half,
	// pin side
	output logic            pin,
	output logic            busy
);
	int left;
	int cnt;
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end
	always @(posedge sys_clk) begin
		if (!busy && start) begin
			busy <= 1'b1;
			left = 2 * n_pulses;
			cnt = half;
		end else if (busy && cnt > 1) begin
			cnt = cnt - 1;
		end else if (busy && left == 0) begin
			busy <= 1'b0;
		end else if (busy) begin
			pin <= ~pin;
			left = left - 1;
			cnt = half;
		end
	end
endmodule : icap_pulse_src

// *** tb/tb_icap_top.sv ***
// Purpose: self-checking bench for the capture block
// Assumes: one pulse source per capture pin
// Notes:   timer2 runs free during capture tests
`timescale 1ns/10ps
module tb_icap_top;
	logic                sys_clk = 1'b0;
	logic                reset = 1'b1;
	icap_pkg::icap_bus_t bus = '0;
	logic                cpu_idle = 1'b0;
	logic                cpu_sleep = 1'b0;
	logic                ext_clk = 1'b0;
	logic                gate3 = 1'b0;
	logic [7:0]          go = 8'h00;
	logic [7:0]          np = 8'h00;
	logic [7:0]          hp = 8'h03;
	logic [7:0]          pins, bz, irq;
	logic [15:0]         rdata, v, a, d, prev;
	logic                wake;
	int                  mismatches = 0;
	int                  total_checks = 0;
	int                  wk = 0;
	icap_pkg::icap_mode_t md[6] = '{icap_pkg::ICAP_EVERY, icap_pkg::ICAP_FALL,
		icap_pkg::ICAP_RISE, icap_pkg::ICAP_DIV4, icap_pkg::ICAP_DIV16,
		icap_pkg::ICAP_INTR};
	int n_ed[6] = '{2, 3, 4, 8, 16, 1};
	int n_cp[6] = '{4, 3, 4, 2, 1, 0};
	logic [15:0] t3c[10] = '{16'h8000, 16'h8010, 16'h8020, 16'h8030,
		16'h8042, 16'h8040, 16'hA000, 16'h0000, 16'h8000, 16'h8040};
	int lo[10] = '{513, 63, 7, 1, 57, 0, 0, 0, 0, 513};
	int hi[10] = '{515, 65, 9, 3, 62, 0, 0, 0, 1, 515};
	always #5 sys_clk = ~sys_clk;
	always #43 ext_clk = ~ext_clk;
	always @(negedge sys_clk) if (wake === 1'b1) wk++;
	icap_top dut (.sys_clk(sys_clk), .reset(reset), .bus(bus),
		.rdata(rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
		.capture_input_pin(pins), .timer2_external_clock_pin(ext_clk),
		.timer3_external_clock_pin(ext_clk), .timer2_gate_pin(1'b0),
		.timer3_gate_pin(gate3), .capture_irq(irq), .wake_req(wake));
	for (genvar g = 0; g < 8; g++) begin : src
		icap_pulse_src u (.sys_clk(sys_clk), .start(go[g]), .n_pulses(np),
			.half(hp), .pin(pins[g]), .busy(bz[g]));
	end
	task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
		@(posedge sys_clk);
		bus <= '{ad, dt, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [15:0] dt);
		@(posedge sys_clk);
		bus <= '{ad, 16'h0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		@(negedge sys_clk);
		dt = rdata;
	endtask : rd
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("ERROR t=%0t %s", $time, m);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#300000;
		mismatches++;
		test_done();
	end
	initial begin
		int ch;
		int c;
		int sel;
		void'($urandom(28));
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			rd(k < 4 ? 8'(k) : 8'h18 + 8'(k - 4) * 8'h10, v);
			chk(v === 16'h0000, "reset or unmapped read");
		end
		a = 16'($urandom) & 16'h7FFF;
		wr(icap_pkg::ADDR_T3_CTRL, a);
		rd(icap_pkg::ADDR_T3_CTRL, v);
		chk(v === (a & icap_pkg::T3_MASK), "t3 control mask");
		wr(icap_pkg::ADDR_T3_CTRL, 16'h0000);
		wr(icap_pkg::ADDR_T2_CTRL, 16'h8000);
		for (int i = 0; i < 6; i++) begin
			ch = (i == 0) ? 0 : $urandom % 8;
			sel = i % 2;
			c = n_cp[i];
			hp <= 8'h03 + 8'($urandom % 4);
			np <= 8'(n_ed[i]);
			cpu_idle <= (i == 2);
			cpu_sleep <= (i == 4);
			wr(icap_pkg::ADDR_CH_BASE + 8'(ch), {8'h00, 1'(sel),
				2'(c == 0 ? 0 : c - 1), 2'b00, md[i]});
			wk = 0;
			go[ch] <= 1'b1;
			@(posedge sys_clk);
			go <= 8'h00;
			@(posedge sys_clk);
			for (int t = 0; t < 2000 && bz !== 8'h00; t++) @(posedge sys_clk);
			repeat (8) @(posedge sys_clk);
			chk(irq === 8'h01 << ch, "irq level");
			chk((wk > 0) === (i == 2 || i == 4), "wake");
			prev = 16'h0000;
			for (int k = 0; k < c; k++) begin
				rd(icap_pkg::ADDR_BUF_BASE + 8'(ch), v);
				chk(sel ? v > prev : v === 16'h0000, "capture");
				prev = v;
			end
			rd(icap_pkg::ADDR_CH_BASE + 8'(ch), v);
			chk(c == 0 || v[3] === 1'b0, "buffer count");
			wr(icap_pkg::ADDR_CH_BASE + 8'(ch), 16'h0100);
			repeat (2) @(posedge sys_clk);
			chk(irq === 8'h00, "irq clear");
			$display("test %0d done", i);
		end
		for (int i = 0; i < 10; i++) begin
			if (i == 8) wr(icap_pkg::ADDR_T2_CTRL, 16'h8008);
			if (i == 9) wr(icap_pkg::ADDR_T2_CTRL, 16'h8000);
			gate3 <= (i == 9);
			cpu_idle <= t3c[i][13];
			wr(icap_pkg::ADDR_T3_CTRL, t3c[i]);
			rd(icap_pkg::ADDR_T3_CNT, a);
			repeat (512) @(posedge sys_clk);
			rd(icap_pkg::ADDR_T3_CNT, v);
			d = v - a;
			chk(d >= lo[i] && d <= hi[i], "t3 rate");
			$display("test %0d done", i + 6);
		end
		test_done();
	end
endmodule : tb_icap_top
bind icap_top icap_props chk_u (.sys_clk(sys_clk), .reset(reset), .bus(bus),
	.rdata(rdata), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
	.capture_irq(capture_irq), .wake_req(wake_req));
